/* hw/lcsp_status_port.sv */
// Summary of operation
// - 16-bit data window reaches the register chosen by the select port.
// - with stop clear, registers one to three ignore writes, read as zero.
// - data window accesses alter the select value only by setting stop, which clears it.
// - register zero readable anytime; reads have no side effect.
// - power-up clears register zero except stop, which is set.
// - bit 15 is OR of bits 14..11, read only.
// - overlong flag sets after 1519 bytes of one frame; frame continues.
// - heartbeat flag sets if no collision within 2 us after transmit.
// - lost-frame flag sets when incoming frame has no receive buffer, except in loopback.
// - DMA timeout flag after 25.6 us without ready; clears bits 5:4.
// - bits 14..8 write-one-to-clear; cleared by stop and resets.
// - receive-done sets on last receive descriptor update or failure.
// - transmit-done sets on last transmit descriptor update or failure.
// - setup-done sets when setup block read and stored while the init bit is set.
// - bit 7 is OR of bits 14,12,11,10,9,8, read only.
// - enabled summary posts request on line two, level 16, vector D5.
// - bit 6 read/write interrupt gate; cleared by stop and resets.
// - select field picks register by value; cleared at reset and stop.
// - setting stop halts activity and clears other register zero bits.
module lcsp_status_port #(
	parameter int DMA_TIMEOUT = lcsp_pkg::DMA_TIMEOUT_CYCLES,
	parameter int HB_WINDOW   = lcsp_pkg::HEARTBEAT_CYCLES
) (
	input  wire logic                mclk,
	input  wire logic                reset_n,
	input  wire logic                io_bus_reset,
	input  wire lcsp_pkg::lcsp_host_t host,
	input  wire lcsp_pkg::lcsp_event_t evt,
	input  wire logic [15:0]         csr1_rdata,
	input  wire logic [15:0]         csr2_rdata,
	input  wire logic [15:0]         csr3_rdata,
	output logic [15:0]              rdata,
	output logic [1:0]               register_pick,
	output logic                     ext_csr_wr,
	output logic [15:0]              ext_csr_wdata,
	output logic                     run_command,
	output logic                     init_command,
	output logic                     stop_state,
	output logic                     request_line_two,
	output logic [4:0]               priority_level,
	output logic [7:0]               vector_offset
);

	// ==========================================================
	// decode
	logic        csr0_wr;
	logic        sel_wr;
	logic        stop_set;
	logic [15:0] w;

	assign w        = host.wdata;
	assign sel_wr   = host.wr && host.sel_port;
	assign csr0_wr  = host.wr && !host.sel_port
		&& register_pick == lcsp_pkg::PICK_CSR0;
	assign stop_set = csr0_wr && w[lcsp_pkg::STOP_BIT];

	function automatic logic w1c(input logic cur, input logic set,
		input logic clr);
		w1c = set ? 1'b1 : (clr ? 1'b0 : cur);
	endfunction

	// ==========================================================
	// select port
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			register_pick <= lcsp_pkg::PICK_RESET;
		end else if (io_bus_reset || stop_set) begin
			register_pick <= lcsp_pkg::PICK_RESET;
		end else if (sel_wr) begin
			register_pick <= w[1:0];
		end
	end

	// ==========================================================
	// control bits
	logic stop_q;
	logic run_q;
	logic init_q;
	logic tdmd_q;
	logic irq_gate_q;
	logic receiver_active_q;
	logic transmitter_active_q;
	logic clear_all;

	assign clear_all = io_bus_reset || stop_set;

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			stop_q <= 1'b1;
		end else if (clear_all) begin
			stop_q <= 1'b1;
		end else if (csr0_wr && (w[lcsp_pkg::RUN_BIT]
			|| w[lcsp_pkg::INIT_BIT])) begin
			stop_q <= 1'b0;
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			run_q <= 1'b0;
		end else if (clear_all) begin
			run_q <= 1'b0;
		end else if (csr0_wr && w[lcsp_pkg::RUN_BIT]) begin
			run_q <= 1'b1;
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			init_q <= 1'b0;
		end else if (clear_all) begin
			init_q <= 1'b0;
		end else if (csr0_wr && w[lcsp_pkg::INIT_BIT]) begin
			init_q <= 1'b1;
		end
	end

	// host demand wins over the engine's acknowledge
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			tdmd_q <= 1'b0;
		end else if (clear_all) begin
			tdmd_q <= 1'b0;
		end else if (csr0_wr && w[lcsp_pkg::TDMD_BIT]) begin
			tdmd_q <= 1'b1;
		end else if (evt.tx_demand_seen) begin
			tdmd_q <= 1'b0;
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			irq_gate_q <= 1'b0;
		end else if (clear_all) begin
			irq_gate_q <= 1'b0;
		end else if (csr0_wr) begin
			irq_gate_q <= w[lcsp_pkg::IRQ_GATE_BIT];
		end
	end

	// ==========================================================
	// timers
	logic [10:0] tx_bytes_q;
	logic [31:0] hb_cnt_q;
	logic        hb_wait_q;
	logic [31:0] dma_cnt_q;
	logic        dma_wait_q;
	logic        overlong_ev;
	logic        heartbeat_ev;
	logic        dma_timeout_ev;

	assign overlong_ev = evt.tx_byte
		&& tx_bytes_q == 11'(lcsp_pkg::BABBLE_BYTES - 1);
	assign heartbeat_ev = hb_wait_q && !evt.collision
		&& hb_cnt_q == 32'(HB_WINDOW - 1);
	assign dma_timeout_ev = dma_wait_q && !evt.dma_ready
		&& dma_cnt_q == 32'(DMA_TIMEOUT - 1);

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			tx_bytes_q <= 11'h000;
		end else if (stop_q || evt.tx_frame_start) begin
			tx_bytes_q <= 11'h000;
		end else if (evt.tx_byte && tx_bytes_q != 11'h7FF) begin
			tx_bytes_q <= tx_bytes_q + 11'h001;
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			hb_wait_q <= 1'b0;
			hb_cnt_q  <= 32'h0;
		end else if (stop_q || evt.collision || heartbeat_ev) begin
			hb_wait_q <= 1'b0;
			hb_cnt_q  <= 32'h0;
		end else if (evt.tx_frame_end) begin
			hb_wait_q <= 1'b1;
			hb_cnt_q  <= 32'h0;
		end else if (hb_wait_q) begin
			hb_cnt_q <= hb_cnt_q + 32'h1;
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			dma_wait_q <= 1'b0;
			dma_cnt_q  <= 32'h0;
		end else if (stop_q || evt.dma_ready || dma_timeout_ev) begin
			dma_wait_q <= 1'b0;
			dma_cnt_q  <= 32'h0;
		end else if (evt.dma_start) begin
			dma_wait_q <= 1'b1;
			dma_cnt_q  <= 32'h0;
		end else if (dma_wait_q) begin
			dma_cnt_q <= dma_cnt_q + 32'h1;
		end
	end

	// ==========================================================
	// sticky flags, set wins over clear
	logic overlong_q;
	logic heartbeat_q;
	logic miss_q;
	logic dma_timeout_q;
	logic rx_done_q;
	logic tx_done_q;
	logic setup_done_q;
	logic [14:8] clr;

	assign clr = csr0_wr ? w[14:8] : 7'h00;

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			overlong_q <= 1'b0;
		end else if (clear_all) begin
			overlong_q <= 1'b0;
		end else begin
			overlong_q <= w1c(overlong_q, overlong_ev, clr[14]);
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			heartbeat_q <= 1'b0;
		end else if (clear_all) begin
			heartbeat_q <= 1'b0;
		end else begin
			heartbeat_q <= w1c(heartbeat_q, heartbeat_ev,
				clr[13]);
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			miss_q <= 1'b0;
		end else if (clear_all) begin
			miss_q <= 1'b0;
		end else begin
			miss_q <= w1c(miss_q, evt.rx_dropped && !evt.loopback,
				clr[12]);
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			dma_timeout_q <= 1'b0;
		end else if (clear_all) begin
			dma_timeout_q <= 1'b0;
		end else begin
			dma_timeout_q <= w1c(dma_timeout_q, dma_timeout_ev,
				clr[11]);
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			rx_done_q <= 1'b0;
		end else if (clear_all) begin
			rx_done_q <= 1'b0;
		end else begin
			rx_done_q <= w1c(rx_done_q,
				evt.rx_desc_last || evt.rx_fail, clr[10]);
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			tx_done_q <= 1'b0;
		end else if (clear_all) begin
			tx_done_q <= 1'b0;
		end else begin
			tx_done_q <= w1c(tx_done_q,
				evt.tx_desc_last || evt.tx_fail, clr[9]);
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			setup_done_q <= 1'b0;
		end else if (clear_all) begin
			setup_done_q <= 1'b0;
		end else begin
			setup_done_q <= w1c(setup_done_q,
				evt.setup_finished && init_q, clr[8]);
		end
	end

	// stay off while the memory timeout flag stands
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			receiver_active_q <= 1'b0;
		end else if (clear_all || dma_timeout_ev) begin
			receiver_active_q <= 1'b0;
		end else if (run_q && !stop_q && !dma_timeout_q) begin
			receiver_active_q <= evt.rx_enable;
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			transmitter_active_q <= 1'b0;
		end else if (clear_all || dma_timeout_ev) begin
			transmitter_active_q <= 1'b0;
		end else if (run_q && !stop_q && !dma_timeout_q) begin
			transmitter_active_q <= evt.tx_enable;
		end
	end

	// ==========================================================
	// summaries and status word
	logic        err_sum;
	logic        irq_summary;
	logic [15:0] csr0;

	assign err_sum = overlong_q | heartbeat_q | miss_q
		| dma_timeout_q;
	assign irq_summary = overlong_q | miss_q | dma_timeout_q
		| rx_done_q | tx_done_q | setup_done_q;
	assign csr0 = {err_sum, overlong_q, heartbeat_q, miss_q,
		dma_timeout_q, rx_done_q, tx_done_q, setup_done_q,
		irq_summary, irq_gate_q, receiver_active_q,
		transmitter_active_q, tdmd_q, stop_q, run_q,
		init_q};

	// ==========================================================
	// registers one to three pass through only while stopped
	assign ext_csr_wr    = host.wr && !host.sel_port
		&& register_pick != lcsp_pkg::PICK_CSR0 && stop_q;
	assign ext_csr_wdata = w;

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			rdata <= 16'h0000;
		end else if (host.rd) begin
			if (host.sel_port)
				rdata <= {14'h0000, register_pick};
			else
				case (register_pick)
					2'h0: rdata <= csr0;
					2'h1: rdata <= stop_q ? csr1_rdata : 16'h0000;
					2'h2: rdata <= stop_q ? csr2_rdata : 16'h0000;
					2'h3: rdata <= stop_q ? csr3_rdata : 16'h0000;
					default: rdata <= 16'h0000;
				endcase
		end
	end

	// ==========================================================
	// interrupt request
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			request_line_two <= 1'b0;
		end else begin
			request_line_two <= irq_summary && irq_gate_q;
		end
	end

	assign priority_level = lcsp_pkg::PRIORITY_LEVEL;
	assign vector_offset  = lcsp_pkg::VECTOR_OFFSET;
	assign run_command    = run_q;
	assign init_command   = init_q;
	assign stop_state     = stop_q;

endmodule

/* hw/lcsp_pkg.sv */
package lcsp_pkg;

	// ==========================================================
	// port addresses and select values
	localparam logic [31:0] DATA_WINDOW_ADDR = 32'h10084400;
	localparam logic [31:0] SELECT_PORT_ADDR = 32'h10084404;
	localparam logic [1:0]  PICK_CSR0        = 2'h0;
	localparam logic [1:0]  PICK_RESET       = 2'h0;

	// ==========================================================
	// controller_status_zero bit positions
	localparam int ERR_BIT   = 15;
	localparam int OVERLONG_BIT    = 14;
	localparam int HEARTBEAT_BIT   = 13;
	localparam int MISS_BIT        = 12;
	localparam int DMA_TIMEOUT_BIT = 11;
	localparam int RX_DONE_BIT     = 10;
	localparam int TX_DONE_BIT     = 9;
	localparam int SETUP_DONE_BIT  = 8;
	localparam int IRQ_SUM_BIT     = 7;
	localparam int IRQ_GATE_BIT    = 6;
	localparam int RX_ACTIVE_BIT   = 5;
	localparam int TX_ACTIVE_BIT   = 4;
	localparam int TDMD_BIT        = 3;
	localparam int STOP_BIT        = 2;
	localparam int RUN_BIT         = 1;
	localparam int INIT_BIT        = 0;
	localparam logic [15:0] CSR0_RESET = 16'h0004;

	// ==========================================================
	// interrupt identity
	localparam logic [4:0] PRIORITY_LEVEL = 5'h16;
	localparam logic [7:0] VECTOR_OFFSET  = 8'hD5;

	// ==========================================================
	// timing
	localparam int CLK_PERIOD_PS     = 10000;
	localparam int BABBLE_BYTES      = 1519;
	localparam int HEARTBEAT_WIN_PS  = 2000000;
	localparam int DMA_TIMEOUT_PS    = 25600000;
	// longest waits, rounded down
	localparam int HEARTBEAT_CYCLES  = HEARTBEAT_WIN_PS / CLK_PERIOD_PS;
	localparam int DMA_TIMEOUT_CYCLES = DMA_TIMEOUT_PS / CLK_PERIOD_PS;

	// ==========================================================
	// host access and engine events
	typedef struct packed {
		logic        rd;
		logic        wr;
		logic        sel_port;
		logic [15:0] wdata;
	} lcsp_host_t;

	typedef struct packed {
		logic tx_byte;
		logic tx_frame_start;
		logic tx_frame_end;
		logic collision;
		logic rx_dropped;
		logic loopback;
		logic dma_start;
		logic dma_ready;
		logic rx_desc_last;
		logic rx_fail;
		logic tx_desc_last;
		logic tx_fail;
		logic setup_finished;
		logic rx_enable;
		logic tx_enable;
		logic tx_demand_seen;
	} lcsp_event_t;

endpackage

/* dv/lcsp_status_port_chk.sv */
module lcsp_status_port_chk (
	input wire logic                 mclk,
	input wire logic                 reset_n,
	input wire logic                 io_bus_reset,
	input wire lcsp_pkg::lcsp_host_t host,
	input wire logic [15:0]          rdata,
	input wire logic [1:0]           register_pick,
	input wire logic                 ext_csr_wr,
	input wire logic [15:0]          ext_csr_wdata,
	input wire logic                 init_command,
	input wire logic                 stop_state,
	input wire logic                 request_line_two,
	input wire logic [4:0]           priority_level,
	input wire logic [7:0]           vector_offset
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!reset_n);
	logic dwin_wr;
	logic stop_wr;
	assign dwin_wr = host.wr && !host.sel_port;
	assign stop_wr = dwin_wr && register_pick == 2'h0 && host.wdata[2];
	// ==========================================================
	// assertions
	a_ext_gated: assert property (ext_csr_wr |-> stop_state)
		else $error("outer register written while running");
	a_ext_taken: assert property (dwin_wr && register_pick != 2'h0
		&& stop_state |-> ext_csr_wr && ext_csr_wdata == host.wdata)
		else $error("outer register write lost");
	a_pick_kept: assert property (!(host.wr && host.sel_port)
		&& !stop_wr && !io_bus_reset |=> $stable(register_pick))
		else $error("select changed without select write");
	a_stop_clears: assert property (stop_wr |=> stop_state
		&& register_pick == 2'h0 && !init_command)
		else $error("stop write did not clear state");
	a_stop_irq: assert property (stop_wr |=> ##1 !request_line_two)
		else $error("request survived stop");
	a_irq_ident: assert property (request_line_two |->
		priority_level == 5'h16 && vector_offset == 8'hD5)
		else $error("wrong interrupt level or vector");
	a_rd_quiet: assert property (!host.rd |=> $stable(rdata))
		else $error("read data moved without read");
	a_io_reset: assert property (io_bus_reset |=> stop_state
		&& register_pick == 2'h0 ##1 !request_line_two)
		else $error("io reset did not restore state");
	a_irq_level: assert property (request_line_two
		&& !$past(host.wr) && !$past(io_bus_reset) |=> request_line_two)
		else $error("request dropped while summary held");
	c_ext_wr: cover property (ext_csr_wr);
	c_irq: cover property ($rose(request_line_two));
	c_stop: cover property (stop_wr);
endmodule

/* dv/lcsp_host_model.sv */
module lcsp_host_model (
	input  wire logic         mclk,
	output lcsp_pkg::lcsp_host_t host,
	input  wire logic [15:0]  rdata
);
	timeunit 1ns;
	timeprecision 100ps;
	// 16-bit words only, upper half never touched
	initial host = '0;
	// select left at register zero by the callers
	task automatic wr(input logic sel, input logic [15:0] d);
		@(posedge mclk);
		#1;
		host.wr = 1'b1;
		host.sel_port = sel;
		host.wdata = d;
		@(posedge mclk);
		#1;
		host.wr = 1'b0;
		host.wdata = ~d;
	endtask
	task automatic rd(input logic sel, output logic [15:0] q);
		@(posedge mclk);
		#1;
		host.rd = 1'b1;
		host.sel_port = sel;
		@(posedge mclk);
		#1;
		host.rd = 1'b0;
		q = rdata;
	endtask
endmodule

/* dv/lan_controller_status_port_test.sv */
module lan_controller_status_port_test;
	timeunit 1ns;
	timeprecision 100ps;
	logic                  mclk = 1'b0;
	logic                  reset_n = 1'b0;
	logic                  io_bus_reset = 1'b0;
	lcsp_pkg::lcsp_host_t  host;
	lcsp_pkg::lcsp_event_t evt = '0;
	logic [15:0]           rdata;
	logic [1:0]            register_pick;
	logic                  stop_state;
	logic                  run_command;
	logic                  request_line_two;
	logic [15:0]           q;
	int                    err_count = 0;
	int                    checks_done = 0;
	// event bit, expected register zero
	logic [15:0] ev [8] = '{16'h0008, 16'h0080, 16'h0040, 16'h0020,
		16'h0010, 16'h0800, 16'h0200, 16'h2000};
	logic [15:0] xp [8] = '{16'h01C1, 16'h04C1, 16'h04C1, 16'h02C1,
		16'h02C1, 16'h90C1, 16'h88C1, 16'hA041};
	always #5 mclk = ~mclk;
	lcsp_host_model hm (.mclk(mclk), .host(host), .rdata(rdata));
	lcsp_status_port #(.DMA_TIMEOUT(20), .HB_WINDOW(10)) DUT (
		.mclk(mclk), .reset_n(reset_n), .io_bus_reset(io_bus_reset),
		.host(host), .evt(evt), .csr1_rdata(16'h1234),
		.csr2_rdata(16'h5678), .csr3_rdata(16'h9ABC), .rdata(rdata),
		.register_pick(register_pick), .ext_csr_wr(), .ext_csr_wdata(),
		.run_command(run_command), .init_command(),
		.stop_state(stop_state),
		.request_line_two(request_line_two), .priority_level(),
		.vector_offset());
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp) begin
			err_count++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic pulse(input logic [15:0] e);
		@(posedge mclk);
		#1;
		evt = lcsp_pkg::lcsp_event_t'(e);
		@(posedge mclk);
		#1;
		evt = '0;
	endtask
	task automatic ev_chk(input logic [15:0] e, input logic [15:0] x);
		pulse(e);
		repeat (25) @(posedge mclk);
		hm.rd(1'b0, q);
		chk(q, x);
		chk({15'h0, request_line_two}, {15'h0, x[7]});
		hm.wr(1'b0, 16'h0040);
		hm.rd(1'b0, q);
		chk(q, x);
		hm.wr(1'b0, x & 16'hFF40);
		hm.rd(1'b0, q);
		chk(q, 16'h0041);
		chk({15'h0, request_line_two}, 16'h0000);
	endtask
	task automatic results();
		$display("checks %0d errors %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	initial begin
		#200000;
		err_count++;
		results();
	end
	initial begin
		repeat (2) @(posedge mclk);
		#1;
		reset_n = 1'b1;
		hm.rd(1'b0, q);
		chk(q, 16'h0004);
		hm.wr(1'b1, 16'h0001);
		hm.rd(1'b0, q);
		chk(q, 16'h1234);
		hm.wr(1'b0, 16'hBEEF);
		hm.rd(1'b1, q);
		chk(q, 16'h0001);
		hm.wr(1'b1, 16'h0000);
		hm.wr(1'b0, 16'h0041);
		hm.wr(1'b1, 16'h0002);
		hm.wr(1'b0, 16'h5555);
		hm.rd(1'b0, q);
		chk(q, 16'h0000);
		hm.wr(1'b1, 16'h0000);
		for (int i = 0; i < 8; i++) begin
			ev_chk(ev[i], xp[i]);
		end
		pulse(16'h4000);
		repeat (1518) pulse(16'h8000);
		hm.rd(1'b0, q);
		chk(q, 16'h0041);
		ev_chk(16'h8000, 16'hC0C1);
		pulse(16'h0080);
		hm.wr(1'b0, 16'h0004);
		hm.rd(1'b0, q);
		chk(q, 16'h0004);
		hm.wr(1'b0, 16'h0041);
		hm.wr(1'b1, 16'h0003);
		pulse(16'h0080);
		@(posedge mclk);
		#1;
		io_bus_reset = 1'b1;
		@(posedge mclk);
		#1;
		io_bus_reset = 1'b0;
		hm.rd(1'b1, q);
		chk(q, 16'h0000);
		hm.rd(1'b0, q);
		chk(q, 16'h0004);
		chk({15'h0, stop_state}, 16'h0001);
		hm.wr(1'b0, 16'h0042);
		@(posedge mclk);
		#1;
		evt = lcsp_pkg::lcsp_event_t'(16'h0006);
		hm.rd(1'b0, q);
		chk(q, 16'h0072);
		chk({15'h0, run_command}, 16'h0001);
		@(posedge mclk);
		#1;
		evt = lcsp_pkg::lcsp_event_t'(16'h0206);
		@(posedge mclk);
		#1;
		evt = lcsp_pkg::lcsp_event_t'(16'h0006);
		repeat (25) @(posedge mclk);
		hm.rd(1'b0, q);
		chk(q, 16'h88C2);
		evt = '0;
		hm.wr(1'b0, 16'h0004);
		hm.rd(1'b0, q);
		chk(q, 16'h0004);
		chk({15'h0, run_command}, 16'h0000);
		results();
	end
endmodule
bind lcsp_status_port lcsp_status_port_chk u_chk (
	.mclk(mclk), .reset_n(reset_n), .io_bus_reset(io_bus_reset),
	.host(host), .rdata(rdata), .register_pick(register_pick),
	.ext_csr_wr(ext_csr_wr), .ext_csr_wdata(ext_csr_wdata),
	.init_command(init_command), .stop_state(stop_state),
	.request_line_two(request_line_two),
	.priority_level(priority_level), .vector_offset(vector_offset));
